// ===== hdl/tmcc_pkg.sv
// constants and carrier types of the timer mode and capture control block
// assumes one 25 MHz clock and a prescaler outside that supplies count enables
package tmcc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] TMCC_ADDR_MODE1 = 16'hFFB6;
  localparam logic [15:0] TMCC_ADDR_CCCTL1 = 16'hFFB8;
  localparam logic [15:0] TMCC_ADDR_MODE0 = 16'hFFBA;
  localparam logic [15:0] TMCC_ADDR_CCCTL0 = 16'hFFBC;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TMCC_MODE_W = 4;
  localparam int TMCC_CCCTL_W = 3;
  localparam int TMCC_BIT_WRAP = 0;
  localparam int TMCC_BIT_TOGGLE = 1;
  localparam int TMCC_BIT_MODE_LO = 2;
  localparam int TMCC_BIT_MODE_HI = 3;
  localparam int TMCC_BIT_ROLE0 = 0;
  localparam int TMCC_BIT_TRIG = 1;
  localparam int TMCC_BIT_ROLE1 = 2;
  localparam logic [3:0] TMCC_MODE_RST = 4'h0;
  localparam logic [2:0] TMCC_CCCTL_RST = 3'h0;
  localparam logic [15:0] TMCC_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TMCC_COUNT_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMCC_STOP = 2'h0,
    TMCC_FREE = 2'h1,
    TMCC_EDGE_CLR = 2'h2,
    TMCC_MATCH_CLR = 2'h3
  } tmcc_mode_t;

  typedef enum logic [1:0] {
    TMCC_ES_FALL = 2'h0,
    TMCC_ES_RISE = 2'h1,
    TMCC_ES_BAD = 2'h2,
    TMCC_ES_BOTH = 2'h3
  } tmcc_edge_sel_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic byte_wr;
    logic bit_wr;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
    logic rd;
  } tmcc_bus_t;

  typedef struct packed {
    logic wr;
    logic ch;
    logic sel;
    logic [15:0] data;
  } tmcc_ccw_t;

  typedef struct packed {
    logic [3:0] mode_ctl;
    logic [2:0] cc_ctl;
    logic [15:0] count;
    logic [15:0] cc0;
    logic [15:0] cc1;
    logic tout;
    logic irq0;
    logic irq1;
  } tmcc_chan_t;

  typedef struct packed {
    tmcc_chan_t [1:0] ch;
    logic [7:0] rdata;
  } tmcc_state_t;

  typedef struct packed {
    logic prev;
  } tmcc_edge_st_t;

endpackage

// ===== hdl/tmcc_edge.sv
// valid edge and reverse phase edge detector for one timer input pin
// assumes the pin is already synchronous to clk
module tmcc_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin and edge selection
  input wire logic pin,
  input wire tmcc_pkg::tmcc_edge_sel_t edge_sel,
  // detected events
  output logic valid_edge,
  output logic reverse_edge
);
  import tmcc_pkg::*;

  tmcc_edge_st_t st_reg;
  tmcc_edge_st_t st_next;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  always_comb begin
    st_next.prev = pin;
    rise = pin & ~st_reg.prev;
    fall = ~pin & st_reg.prev;
    case (edge_sel)
      TMCC_ES_FALL: begin
        valid_edge = fall;
        reverse_edge = rise;
      end
      TMCC_ES_RISE: begin
        valid_edge = rise;
        reverse_edge = fall;
      end
      TMCC_ES_BOTH: begin
        valid_edge = rise | fall;
        // no opposite phase exists when both edges count
        reverse_edge = 1'b0;
      end
      default: begin
        valid_edge = 1'b0;
        reverse_edge = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ===== hdl/tmcc_top.sv
// two channel timer mode, overflow and capture/compare control
// assumes count enables from an outside prescaler and synchronous pins
// Function
// - channel 0 modes: stop and clear, free run, edge clear, match clear
// - counting starts when mode becomes nonzero, stops only on mode 00
// - reset clears both mode and capture/compare control registers
// - channel 0 output toggles on matches, plus input a edge if selected
// - channel 1 output toggles on either match, toggle bit ignored
// - wrap flag sets when the counter passes from maximum to zero
// - wrap flag clears on written zero or on stop mode
// - writing one to the wrap flag sets it, except in mode 00 where it stays clear
// - control bit 2 picks compare or capture for second register
// - control bit 0 picks compare or capture for first register
// - channel 0 bit 1 picks input b edge or reverse phase input a
// - with reverse phase, input b edge only raises first interrupt
// - reverse phase with both edges selected detects no edge
// - edge select: 00 falling, 01 rising, 11 both, 10 forbidden
// - compare role registers match the counter and raise interrupts
module tmcc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire tmcc_pkg::tmcc_bus_t bus,
  output logic [7:0] bus_rdata,
  // capture/compare data write port
  input wire tmcc_pkg::tmcc_ccw_t ccw,
  // prescaled count enables and edge selects
  input wire logic [1:0] count_en,
  input wire tmcc_pkg::tmcc_edge_sel_t edge_sel_a,
  input wire tmcc_pkg::tmcc_edge_sel_t edge_sel_b,
  input wire tmcc_pkg::tmcc_edge_sel_t edge_sel_ch1,
  // timer pins
  input wire logic ext_input_a,
  input wire logic ext_input_b,
  input wire logic ch1_ext_input,
  output logic [1:0] timer_out_pin,
  // events and counter views
  output logic [1:0] first_match_irq,
  output logic [1:0] second_match_irq,
  output logic [1:0][15:0] count_register,
  output logic [1:0][15:0] first_capcmp_reg,
  output logic [1:0][15:0] second_capcmp_reg
);
  import tmcc_pkg::*;

  tmcc_state_t st_reg;
  tmcc_state_t st_next;
  logic va;
  logic ra;
  logic vb;
  logic v1;
  logic [1:0] run;
  logic [1:0] m0;
  logic [1:0] m1;
  logic [1:0] cap0;
  logic [1:0] cap1;
  logic [1:0] clr;
  logic [1:0] wrap;
  logic [1:0] ext_irq;
  logic [1:0] tog_edge;
  logic [1:0] cc0_trig;
  logic [1:0] cc1_trig;
  logic [1:0] cap0_irq;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_mode_addr(input logic [15:0] a, input int c);
    return a == ((c == 0) ? TMCC_ADDR_MODE0 : TMCC_ADDR_MODE1);
  endfunction

  function automatic logic is_ccctl_addr(input logic [15:0] a, input int c);
    return a == ((c == 0) ? TMCC_ADDR_CCCTL0 : TMCC_ADDR_CCCTL1);
  endfunction

  // ----------------------------------------------------------------
  // pin edge detectors
  // ----------------------------------------------------------------
  tmcc_edge u_edge_a (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_input_a),
    .edge_sel(edge_sel_a),
    .valid_edge(va),
    .reverse_edge(ra)
  );

  tmcc_edge u_edge_b (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_input_b),
    .edge_sel(edge_sel_b),
    .valid_edge(vb),
    .reverse_edge()
  );

  tmcc_edge u_edge_ch1 (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ch1_ext_input),
    .edge_sel(edge_sel_ch1),
    .valid_edge(v1),
    .reverse_edge()
  );

  // ----------------------------------------------------------------
  // trigger routing per channel
  // ----------------------------------------------------------------
  always_comb begin
    // channel 1 has no edge clear mode, so it never clears on an edge
    clr[1] = 1'b0;
    cc0_trig[1] = v1;
    cc1_trig[1] = v1;
    ext_irq[1] = 1'b0;
    tog_edge[1] = 1'b0;
    cap0_irq[1] = 1'b1;
    clr[0] = va;
    cc0_trig[0] = st_reg.ch[0].cc_ctl[TMCC_BIT_TRIG] ? ra : vb;
    cc1_trig[0] = va;
    ext_irq[0] = st_reg.ch[0].cc_ctl[TMCC_BIT_TRIG] & vb;
    tog_edge[0] = st_reg.ch[0].mode_ctl[TMCC_BIT_TOGGLE] & va;
    // a reverse phase capture raises no interrupt of its own
    cap0_irq[0] = ~st_reg.ch[0].cc_ctl[TMCC_BIT_TRIG];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    for (int c = 0; c < 2; c++) begin
      run[c] = st_reg.ch[c].mode_ctl[TMCC_BIT_MODE_HI:TMCC_BIT_MODE_LO] != TMCC_STOP;
      m0[c] = run[c] & count_en[c] & ~st_reg.ch[c].cc_ctl[TMCC_BIT_ROLE0]
              & (st_reg.ch[c].count == st_reg.ch[c].cc0);
      m1[c] = run[c] & count_en[c] & ~st_reg.ch[c].cc_ctl[TMCC_BIT_ROLE1]
              & (st_reg.ch[c].count == st_reg.ch[c].cc1);
      cap0[c] = run[c] & st_reg.ch[c].cc_ctl[TMCC_BIT_ROLE0] & cc0_trig[c];
      cap1[c] = run[c] & st_reg.ch[c].cc_ctl[TMCC_BIT_ROLE1] & cc1_trig[c];
      wrap[c] = 1'b0;
      // counter
      if (!run[c]) begin
        st_next.ch[c].count = 16'h0000;
      end else if (count_en[c]) begin
        if ((st_reg.ch[c].mode_ctl[3:2] == TMCC_EDGE_CLR && clr[c])
            || (st_reg.ch[c].mode_ctl[3:2] == TMCC_MATCH_CLR && m0[c])) begin
          st_next.ch[c].count = 16'h0000;
        end else begin
          st_next.ch[c].count = st_reg.ch[c].count + TMCC_COUNT_ONE;
          wrap[c] = st_reg.ch[c].count == TMCC_COUNT_MAX;
        end
      end
      // events and output
      st_next.ch[c].irq0 = m0[c] | (cap0[c] & cap0_irq[c]) | (run[c] & ext_irq[c]);
      st_next.ch[c].irq1 = m1[c] | cap1[c];
      st_next.ch[c].tout = st_reg.ch[c].tout
                           ^ (m0[c] | m1[c] | (run[c] & tog_edge[c]));
      // capture and data writes
      if (cap0[c]) begin
        st_next.ch[c].cc0 = st_reg.ch[c].count;
      end
      if (cap1[c]) begin
        st_next.ch[c].cc1 = st_reg.ch[c].count;
      end
      if (ccw.wr && ccw.ch == c[0]) begin
        if (ccw.sel) begin
          st_next.ch[c].cc1 = ccw.data;
        end else begin
          st_next.ch[c].cc0 = ccw.data;
        end
      end
      // control register writes
      if (is_mode_addr(bus.addr, c)) begin
        if (bus.byte_wr) begin
          st_next.ch[c].mode_ctl = bus.wdata[TMCC_MODE_W-1:0];
        end else if (bus.bit_wr && bus.bit_idx < 3'h4) begin
          st_next.ch[c].mode_ctl[bus.bit_idx[1:0]] = bus.wdata[0];
        end
        if (bus.rd) begin
          st_next.rdata = {4'h0, st_reg.ch[c].mode_ctl};
        end
      end
      if (is_ccctl_addr(bus.addr, c)) begin
        if (bus.byte_wr) begin
          st_next.ch[c].cc_ctl = bus.wdata[TMCC_CCCTL_W-1:0];
        end else if (bus.bit_wr && bus.bit_idx < 3'h3) begin
          st_next.ch[c].cc_ctl[bus.bit_idx[1:0]] = bus.wdata[0];
        end
        if (bus.rd) begin
          st_next.rdata = {5'h00, st_reg.ch[c].cc_ctl};
        end
      end
      // a wrap in the same cycle as a software clear still sets the flag
      if (wrap[c]) begin
        st_next.ch[c].mode_ctl[TMCC_BIT_WRAP] = 1'b1;
      end
      if (st_next.ch[c].mode_ctl[3:2] == TMCC_STOP) begin
        st_next.ch[c].mode_ctl[TMCC_BIT_WRAP] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata = st_reg.rdata;
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign timer_out_pin[g] = st_reg.ch[g].tout;
    assign first_match_irq[g] = st_reg.ch[g].irq0;
    assign second_match_irq[g] = st_reg.ch[g].irq1;
    assign count_register[g] = st_reg.ch[g].count;
    assign first_capcmp_reg[g] = st_reg.ch[g].cc0;
    assign second_capcmp_reg[g] = st_reg.ch[g].cc1;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic bus_quiet;
  assign bus_quiet = ~bus.byte_wr & ~bus.bit_wr;

  a_stop_count_zero: assert property (
    st_reg.ch[0].mode_ctl[3:2] == TMCC_STOP |=> st_reg.ch[0].count == 16'h0000
  ) else $error("stopped counter not cleared");
  a_run_count_step: assert property (
    st_reg.ch[1].mode_ctl[3:2] == TMCC_FREE && count_en[1] && bus_quiet
    |=> st_reg.ch[1].count == $past(st_reg.ch[1].count) + TMCC_COUNT_ONE
  ) else $error("running counter did not advance");
  a_match_clear_zero: assert property (
    st_reg.ch[0].mode_ctl[3:2] == TMCC_MATCH_CLR && m0[0] |=> st_reg.ch[0].count == 16'h0000
  ) else $error("match clear did not clear counter");
  a_wrap_sets_flag: assert property (
    st_reg.ch[0].mode_ctl[3:2] == TMCC_FREE && count_en[0] && bus_quiet
    && st_reg.ch[0].count == TMCC_COUNT_MAX |=> st_reg.ch[0].mode_ctl[0] ##1 1'b1
  ) else $error("wrap flag not set");
  a_stop_clears_flag: assert property (
    st_reg.ch[1].mode_ctl[3:2] == TMCC_STOP |-> !st_reg.ch[1].mode_ctl[0]
  ) else $error("wrap flag set while stopped");
  a_flag_write_one: assert property (
    bus.byte_wr && bus.addr == TMCC_ADDR_MODE0 && bus.wdata[0] && bus.wdata[3:2] != 2'h0
    |=> st_reg.ch[0].mode_ctl[0]
  ) else $error("written one did not set wrap flag");
  a_match_irq_pulse: assert property (
    m1[0] |=> second_match_irq[0]
  ) else $error("match interrupt missing");
  a_ch1_toggle: assert property (
    (m0[1] ^ m1[1]) |=> timer_out_pin[1] != $past(timer_out_pin[1])
  ) else $error("channel 1 output did not toggle");
  a_bit_write_only: assert property (
    bus.bit_wr && !bus.byte_wr && bus.addr == TMCC_ADDR_CCCTL1 && bus.bit_idx == 3'h1
    |=> st_reg.ch[1].cc_ctl[2] == $past(st_reg.ch[1].cc_ctl[2])
        && st_reg.ch[1].cc_ctl[0] == $past(st_reg.ch[1].cc_ctl[0])
  ) else $error("bit write disturbed other bits");
  a_rev_no_capture: assert property (
    run[0] && st_reg.ch[0].cc_ctl[1:0] == 2'h3 && vb && !ra && !ccw.wr
    |=> first_match_irq[0] && st_reg.ch[0].cc0 == $past(st_reg.ch[0].cc0)
  ) else $error("input b edge captured in reverse phase mode");
  a_second_capture: assert property (
    cap1[0] && !ccw.wr |=> st_reg.ch[0].cc1 == $past(st_reg.ch[0].count)
  ) else $error("second register capture wrong");
  a_first_capture: assert property (
    cap0[0] && !ccw.wr |=> st_reg.ch[0].cc0 == $past(st_reg.ch[0].count)
  ) else $error("first register capture wrong");
  a_edge_toggle: assert property (
    run[0] && st_reg.ch[0].mode_ctl[TMCC_BIT_TOGGLE] && va && !m0[0] && !m1[0]
    |=> timer_out_pin[0] != $past(timer_out_pin[0])
  ) else $error("input a edge did not toggle output");
  a_both_no_reverse: assert property (
    edge_sel_a == TMCC_ES_BOTH |-> !ra
  ) else $error("reverse phase edge seen with both edges selected");

  c_wrap: cover property (wrap[0]);
  c_match_clear: cover property (st_reg.ch[1].mode_ctl[3:2] == TMCC_MATCH_CLR && m0[1]);
  c_edge_clear: cover property (st_reg.ch[0].mode_ctl[3:2] == TMCC_EDGE_CLR && va && count_en[0]);
  c_rev_capture: cover property (cap0[0] && st_reg.ch[0].cc_ctl[1]);

endmodule

// ===== test/tmcc_pin_model.sv
// pin side model: drives the three timer input pins from levels the bench asks for
// assumes count enables run on every clock, so one clock is one count clock
module tmcc_pin_model #(
  parameter int HOLD = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // requested and driven levels: bit 0 input a, bit 1 input b, bit 2 channel 1 input
  input wire logic [2:0] want,
  output logic [2:0] pins
);
  logic [2:0][3:0] age;

  // a level is kept at least HOLD clocks, so no pulse is shorter than the capture needs;
  // a larger HOLD makes the pins answer slowly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins <= 3'h0;
      age <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (want[i] != pins[i] && age[i] >= HOLD) begin
          pins[i] <= want[i];
          age[i] <= 4'h0;
        end else if (age[i] != 4'hF) begin
          age[i] <= age[i] + 4'h1;
        end
      end
    end
  end
endmodule

// ===== test/test_timer_mode_capture_control.sv
// self-checking bench of the timer mode and capture control block
// assumes the package, the design and the pin model are compiled before it
module test_timer_mode_capture_control;
  timeunit 1ns;
  timeprecision 1ps;
  import tmcc_pkg::*;
  logic clk;
  logic rst_b;
  tmcc_bus_t bus;
  logic [7:0] bus_rdata;
  tmcc_ccw_t ccw;
  logic [1:0] count_en;
  tmcc_edge_sel_t es_a;
  tmcc_edge_sel_t es_b;
  tmcc_edge_sel_t es_c1;
  logic [2:0] want;
  logic [2:0] pins;
  logic [1:0] tout;
  logic [1:0] irq0;
  logic [1:0] irq1;
  logic [1:0][15:0] cnt;
  logic [1:0][15:0] cc0;
  logic [1:0][15:0] cc1;
  int err_total;
  int comparisons;
  int k;
  logic [15:0] r;
  logic [15:0] n;
  logic [15:0] c;
  logic t0;
  logic [15:0] adr [4];
  logic [7:0] dat [4];

  tmcc_top uut (
    .clk(clk), .rst_b(rst_b), .bus(bus), .bus_rdata(bus_rdata), .ccw(ccw),
    .count_en(count_en), .edge_sel_a(es_a), .edge_sel_b(es_b), .edge_sel_ch1(es_c1),
    .ext_input_a(pins[0]), .ext_input_b(pins[1]), .ch1_ext_input(pins[2]),
    .timer_out_pin(tout), .first_match_irq(irq0), .second_match_irq(irq1),
    .count_register(cnt), .first_capcmp_reg(cc0), .second_capcmp_reg(cc1)
  );

  tmcc_pin_model pinm (.clk(clk), .rst_b(rst_b), .want(want), .pins(pins));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // every request opens one edge after the last, so no strobe is set twice at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    step();
    bus.addr = a;
    bus.wdata = d;
    bus.byte_wr = 1'b1;
    step();
    bus.byte_wr = 1'b0;
  endtask

  task automatic wbit(input logic [15:0] a, input logic [2:0] i, input logic v);
    step();
    bus.addr = a;
    bus.bit_idx = i;
    bus.wdata = {7'h00, v};
    bus.bit_wr = 1'b1;
    step();
    bus.bit_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    step();
    bus.addr = a;
    bus.rd = 1'b1;
    step();
    bus.rd = 1'b0;
    d = {8'h00, bus_rdata};
  endtask

  task automatic cc_wr(input logic ch, input logic sel, input logic [15:0] d);
    step();
    ccw = '{wr: 1'b1, ch: ch, sel: sel, data: d};
    step();
    ccw.wr = 1'b0;
  endtask

  task automatic wait_irq(input int ch, output int kk);
    kk = 0;
    do begin
      step();
      kk++;
    end while (irq0[ch] !== 1'b1 && kk < 200);
  endtask

  // read-back of a written byte: unused upper bits read as zero
  function automatic logic [15:0] rb(input logic [15:0] a, input logic [7:0] d);
    logic is_mode;
    is_mode = (a == TMCC_ADDR_MODE0) || (a == TMCC_ADDR_MODE1);
    rb = {8'h00, d & (is_mode ? 8'h0F : 8'h07)};
  endfunction

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // longest case is one full wrap of a counter, 65536 clocks
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    bus = '0;
    ccw = '0;
    count_en = 2'h3;
    es_a = TMCC_ES_RISE;
    es_b = TMCC_ES_RISE;
    es_c1 = TMCC_ES_RISE;
    want = 3'h0;
    err_total = 0;
    comparisons = 0;
    adr = '{TMCC_ADDR_MODE1, TMCC_ADDR_CCCTL1, TMCC_ADDR_MODE0, TMCC_ADDR_CCCTL0};
    dat = '{8'hF2, 8'hF5, 8'hF2, 8'hFF}; // mode fields stay 00, channel 1 trigger 0
    r = 16'($urandom(32'hB85E649D));
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    rd(16'hFFB7, r);
    check(r, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], r);
      check(r, 16'h0000);
      wr(adr[i], dat[i]);
      rd(adr[i], r);
      check(r, rb(adr[i], dat[i]));
    end
    // a written one cannot hold the flag while the channel is stopped
    wbit(TMCC_ADDR_MODE0, 3'h0, 1'b1);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0002);
    wbit(TMCC_ADDR_CCCTL1, 3'h1, 1'b0);
    rd(TMCC_ADDR_CCCTL1, r);
    check(r, 16'h0005);
    wbit(TMCC_ADDR_MODE0, 3'h0, 1'b0);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 8'h00);
    end
    // free run, then stop clears the counter
    n = 16'($urandom_range(12, 40));
    wr(TMCC_ADDR_MODE0, 8'h04);
    repeat (n) step();
    check(cnt[0], n);
    check(cnt[1], 16'h0000);
    wr(TMCC_ADDR_MODE0, 8'h00);
    step();
    check(cnt[0], 16'h0000);
    // clear on match, both channels; second register parked out of reach
    for (int ch = 0; ch < 2; ch++) begin
      n = 16'($urandom_range(3, 60));
      cc_wr(ch[0], 1'b0, n);
      check(cc0[ch], n);
      cc_wr(ch[0], 1'b1, TMCC_COUNT_MAX);
      t0 = tout[ch];
      wr(ch ? TMCC_ADDR_MODE1 : TMCC_ADDR_MODE0, 8'h0E); // first register kept compare
      wait_irq(ch, k);
      check(16'(k), n + 16'h1);
      check(cnt[ch], 16'h0000);
      check({15'h0, tout[ch]}, {15'h0, ~t0});
      wr(ch ? TMCC_ADDR_MODE1 : TMCC_ADDR_MODE0, 8'h00);
    end
    c = cc0[0];
    // full wrap of channel 0 sets the flag; only flag or stop writes while running
    wr(TMCC_ADDR_MODE0, 8'h04);
    k = 0;
    while (cnt[0] !== TMCC_COUNT_MAX && k < 70000) begin
      step();
      k++;
    end
    step();
    check(cnt[0], 16'h0000);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0005);
    wbit(TMCC_ADDR_MODE0, 3'h0, 1'b0);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0004);
    // setting the flag by software is a full rewrite, so it waits for a stop
    wr(TMCC_ADDR_MODE0, 8'h00);
    wr(TMCC_ADDR_MODE0, 8'h05);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0005);
    wr(TMCC_ADDR_MODE0, 8'h00);
    rd(TMCC_ADDR_MODE0, r);
    check(r, 16'h0000);
    // reverse phase capture on the first register, input a capture on the second
    wr(TMCC_ADDR_CCCTL0, 8'h07);
    wr(TMCC_ADDR_MODE0, 8'h04);
    repeat (20) step();
    want = 3'h2;
    wait_irq(0, k);
    check({15'h0, irq0[0]}, 16'h0001);
    check(cc0[0], c);
    want = 3'h3;
    k = 0;
    while (pins[0] !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    n = cnt[0];
    repeat (8) step();
    check(cc0[0], c);
    check(cc1[0], n);
    want = 3'h2;
    k = 0;
    while (pins[0] !== 1'b0 && k < 20) begin
      step();
      k++;
    end
    c = cnt[0];
    repeat (3) step();
    check(cc0[0], c);
    wr(TMCC_ADDR_MODE0, 8'h00);
    // edge clear on both edges of input a; channel 1 captures on its own pin
    es_a = TMCC_ES_BOTH;
    wr(TMCC_ADDR_CCCTL0, 8'h04);
    wr(TMCC_ADDR_CCCTL1, 8'h04);
    wr(TMCC_ADDR_MODE1, 8'h04);
    wr(TMCC_ADDR_MODE0, 8'h0A);
    repeat (4) step();
    want = 3'h7;
    k = 0;
    while (pins[0] !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    n = cnt[0];
    c = cnt[1];
    t0 = tout[0];
    step();
    check(cnt[0], 16'h0000);
    check(cc1[0], n);
    check(cc1[1], c);
    check({14'h0, irq1}, 16'h0003);
    check({15'h0, tout[0]}, {15'h0, ~t0});
    repeat (4) step();
    want = 3'h2;
    k = 0;
    while (pins[0] !== 1'b0 && k < 20) begin
      step();
      k++;
    end
    step();
    check(cnt[0], 16'h0000);
    wr(TMCC_ADDR_MODE0, 8'h00);
    wr(TMCC_ADDR_MODE1, 8'h00);
    close_out();
  end
endmodule
